// >>> pmsa_regs.svh
// register offsets, field positions, reset values and addresses of the phy status bank
`ifndef PMSA_REGS_SVH
`define PMSA_REGS_SVH

`define PMSA_REG_STATUS       5'h01
`define PMSA_REG_ID_UPPER     5'h02
`define PMSA_REG_ID_LOWER     5'h03
`define PMSA_REG_ADVERT       5'h04
`define PMSA_REG_PARTNER      5'h05

`define PMSA_PHYAD_PORT1      5'h01
`define PMSA_PHYAD_PORT2      5'h02

`define PMSA_CAP_BITS         5'h0F
`define PMSA_SELECTOR         5'h01
`define PMSA_ADV_RESET        5'h1F
`define PMSA_IDLE_WORD        16'hFFFF
`define PMSA_ZERO_WORD        16'h0000

`define PMSA_BIT_ADV_PAUSE    10
`define PMSA_BIT_ADV_100F     8
`define PMSA_BIT_ADV_10H      5
`define PMSA_BIT_AN_DONE      5
`define PMSA_BIT_FAULT        4
`define PMSA_BIT_AN_ABILITY   3
`define PMSA_BIT_LINK         2

`endif

// >>> pmsa_pkg.sv
// shared types of the phy status bank
package pmsa_pkg;
    // {pause, 100 full, 100 half, 10 full, 10 half}, same order as the port control bits 4..0
    typedef logic [4:0]  pmsa_ability_type;
    typedef logic [15:0] pmsa_word_type;
    typedef logic [4:0]  pmsa_addr_type;
endpackage : pmsa_pkg

// >>> pmsa_port.sv
// one phy port: advertisement storage and read word composition
`timescale 1ns/1ps
`default_nettype none
`include "pmsa_regs.svh"
module pmsa_port (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // management write to the advertisement register
    input  wire logic                      mgmt_wr_en,
    input  wire pmsa_pkg::pmsa_word_type   mgmt_wdata,
    // alias write from the port control register side
    input  wire logic                      ctl_wr_en,
    input  wire pmsa_pkg::pmsa_ability_type ctl_wr_bits,
    // live port state
    input  wire logic                      link_up,
    input  wire logic                      an_done,
    input  wire logic                      an_ability,
    input  wire logic                      far_end_fault,
    input  wire pmsa_pkg::pmsa_ability_type partner_bits,
    // read side
    input  wire pmsa_pkg::pmsa_addr_type   reg_addr,
    input  wire pmsa_pkg::pmsa_word_type   id_upper,
    input  wire pmsa_pkg::pmsa_word_type   id_lower,
    output logic [4:0]                     adv_bits,
    output pmsa_pkg::pmsa_word_type        rd_word
);
    import pmsa_pkg::*;

    // one storage for both views, so the two paths can never disagree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adv_bits <= `PMSA_ADV_RESET;
        end else if (mgmt_wr_en) begin
            // only bits 10 and 8..5 are writable; the rest are dropped here
            adv_bits <= {mgmt_wdata[`PMSA_BIT_ADV_PAUSE],
                         mgmt_wdata[`PMSA_BIT_ADV_100F:`PMSA_BIT_ADV_10H]};
        end else if (ctl_wr_en) begin
            adv_bits <= ctl_wr_bits;
        end
    end

    always_comb begin
        rd_word = `PMSA_ZERO_WORD;
        unique case (reg_addr)
            `PMSA_REG_STATUS: begin
                rd_word[14:11]               = 4'hF;
                rd_word[15]                  = 1'b0;
                rd_word[`PMSA_BIT_AN_DONE]    = an_done;
                rd_word[`PMSA_BIT_FAULT]      = far_end_fault;
                rd_word[`PMSA_BIT_AN_ABILITY] = an_ability;
                rd_word[`PMSA_BIT_LINK]       = link_up;
            end
            `PMSA_REG_ID_UPPER: begin
                rd_word = id_upper;
            end
            `PMSA_REG_ID_LOWER: begin
                rd_word = id_lower;
            end
            `PMSA_REG_ADVERT: begin
                rd_word[`PMSA_BIT_ADV_PAUSE]                   = adv_bits[4];
                rd_word[`PMSA_BIT_ADV_100F:`PMSA_BIT_ADV_10H]  = adv_bits[3:0];
                rd_word[4:0]                                   = `PMSA_SELECTOR;
            end
            `PMSA_REG_PARTNER: begin
                rd_word[`PMSA_BIT_ADV_PAUSE]                   = partner_bits[4];
                rd_word[`PMSA_BIT_ADV_100F:`PMSA_BIT_ADV_10H]  = partner_bits[3:0];
            end
            default: begin
                rd_word = `PMSA_ZERO_WORD;
            end
        endcase
    end
endmodule : pmsa_port
`default_nettype wire

// >>> pmsa_top.sv
// phy management status, identifier and ability register bank for two ports
`timescale 1ns/1ps
`default_nettype none
`include "pmsa_regs.svh"
module pmsa_top #(
    // arbitrary neutral identifier values
    parameter logic [15:0] ID_UPPER = 16'h0A5C,
    parameter logic [15:0] ID_LOWER = 16'h3C70
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // management access, one request per cycle that mgmt_req is high
    input  wire logic                       mgmt_req,
    input  wire logic                       mgmt_write,
    input  wire pmsa_pkg::pmsa_addr_type    mgmt_phy_addr,
    input  wire pmsa_pkg::pmsa_addr_type    mgmt_reg_addr,
    input  wire pmsa_pkg::pmsa_word_type    mgmt_wdata,
    output logic                            mgmt_ack,
    output logic                            mgmt_hit,
    output pmsa_pkg::pmsa_word_type         mgmt_rdata,
    // converter mode and programmed address
    input  wire logic                       center_mode,
    input  wire logic                       center_addr_valid,
    input  wire pmsa_pkg::pmsa_addr_type    center_phy_addr,
    // alias writes from the port control registers
    input  wire logic                       ctl_wr_en,
    input  wire logic                       ctl_wr_port2,
    input  wire pmsa_pkg::pmsa_ability_type ctl_wr_bits,
    // port 1 state
    input  wire logic                       p1_link_up,
    input  wire logic                       p1_an_done,
    input  wire logic                       p1_an_ability,
    input  wire logic                       p1_far_end_fault,
    input  wire pmsa_pkg::pmsa_ability_type p1_partner_bits,
    // port 2 state
    input  wire logic                       p2_link_up,
    input  wire logic                       p2_an_done,
    input  wire logic                       p2_an_ability,
    input  wire pmsa_pkg::pmsa_ability_type p2_partner_bits,
    // advertised abilities, as seen by the port control registers
    output pmsa_pkg::pmsa_ability_type      p1_adv_bits,
    output pmsa_pkg::pmsa_ability_type      p2_adv_bits
);
    import pmsa_pkg::*;

    // registers this bank serves; register 0 lives in the control bank
    function automatic logic pmsa_reg_served(input pmsa_addr_type ra);
        return (ra >= `PMSA_REG_STATUS) && (ra <= `PMSA_REG_PARTNER);
    endfunction : pmsa_reg_served

    // bit 0 selects port 1, bit 1 port 2; at most one is set
    function automatic logic [1:0] pmsa_port_of(input pmsa_addr_type pa,
                                                 input logic          cm,
                                                 input logic          cv,
                                                 input pmsa_addr_type ca);
        logic [1:0] sel;
        sel = 2'h0;
        if (cm) begin
            // no answer at all until the address has been programmed
            sel[0] = cv && (pa == ca);
        end else begin
            sel[0] = (pa == `PMSA_PHYAD_PORT1);
            sel[1] = (pa == `PMSA_PHYAD_PORT2);
        end
        return sel;
    endfunction : pmsa_port_of

    logic [1:0]     port_sel;
    logic           served;
    logic           adv_write;
    pmsa_word_type  p1_word;
    pmsa_word_type  p2_word;
    pmsa_word_type  next_rdata;
    logic           next_hit;

    assign port_sel  = pmsa_port_of(mgmt_phy_addr, center_mode, center_addr_valid,
                                    center_phy_addr);
    assign served    = mgmt_req && pmsa_reg_served(mgmt_reg_addr) && (port_sel != 2'h0);
    // writes to registers 1, 2, 3 and 5 touch no storage at all
    assign adv_write = served && mgmt_write && (mgmt_reg_addr == `PMSA_REG_ADVERT);

    always_comb begin
        next_hit   = served;
        next_rdata = `PMSA_IDLE_WORD;
        if (served && !mgmt_write) begin
            next_rdata = port_sel[0] ? p1_word : p2_word;
        end
    end

    pmsa_port u_port1 (
        .clk           (clk),
        .rst_b         (rst_b),
        .mgmt_wr_en    (adv_write && port_sel[0]),
        .mgmt_wdata    (mgmt_wdata),
        .ctl_wr_en     (ctl_wr_en && !ctl_wr_port2),
        .ctl_wr_bits   (ctl_wr_bits),
        .link_up       (p1_link_up),
        .an_done       (p1_an_done),
        .an_ability    (p1_an_ability),
        .far_end_fault (p1_far_end_fault),
        .partner_bits  (p1_partner_bits),
        .reg_addr      (mgmt_reg_addr),
        .id_upper      (ID_UPPER),
        .id_lower      (ID_LOWER),
        .adv_bits      (p1_adv_bits),
        .rd_word       (p1_word)
    );

    // far-end fault is tracked for port 1 only
    pmsa_port u_port2 (
        .clk           (clk),
        .rst_b         (rst_b),
        .mgmt_wr_en    (adv_write && port_sel[1]),
        .mgmt_wdata    (mgmt_wdata),
        .ctl_wr_en     (ctl_wr_en && ctl_wr_port2),
        .ctl_wr_bits   (ctl_wr_bits),
        .link_up       (p2_link_up),
        .an_done       (p2_an_done),
        .an_ability    (p2_an_ability),
        .far_end_fault (1'b0),
        .partner_bits  (p2_partner_bits),
        .reg_addr      (mgmt_reg_addr),
        .id_upper      (ID_UPPER),
        .id_lower      (ID_LOWER),
        .adv_bits      (p2_adv_bits),
        .rd_word       (p2_word)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt_ack <= 1'b0;
        end else begin
            mgmt_ack <= mgmt_req;
        end
    end

    // unanswered accesses read as an idle, pulled-up data line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt_hit   <= 1'b0;
            mgmt_rdata <= `PMSA_IDLE_WORD;
        end else if (mgmt_req) begin
            mgmt_hit   <= next_hit;
            mgmt_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // read of a given register on a given port, sampled one cycle before the answer
    logic rd_p1_status;
    logic rd_p2_status;
    logic rd_p1_partner;
    assign rd_p1_status  = mgmt_req && !mgmt_write && port_sel[0]
                           && (mgmt_reg_addr == `PMSA_REG_STATUS);
    assign rd_p2_status  = mgmt_req && !mgmt_write && port_sel[1]
                           && (mgmt_reg_addr == `PMSA_REG_STATUS);
    assign rd_p1_partner = mgmt_req && !mgmt_write && port_sel[0]
                           && (mgmt_reg_addr == `PMSA_REG_PARTNER);

    AST_CAP_ONES: assert property (
        (rd_p1_status || rd_p2_status) |=> mgmt_ack && (mgmt_rdata[14:11] == 4'hF))
        else $error("capability bits not all one");

    AST_NO_FOUR_PAIR: assert property (
        (rd_p1_status || rd_p2_status) |=> !mgmt_rdata[15])
        else $error("four-pair bit set");

    AST_AN_DONE: assert property (
        rd_p2_status |=> mgmt_rdata[`PMSA_BIT_AN_DONE] == $past(p2_an_done))
        else $error("autoneg done bit wrong");

    // port 2 has no fault source, so its bit must stay low
    AST_FAULT: assert property (
        (rd_p1_status |=> mgmt_rdata[`PMSA_BIT_FAULT] == $past(p1_far_end_fault))
        and (rd_p2_status |=> !mgmt_rdata[`PMSA_BIT_FAULT]))
        else $error("far-end fault bit wrong");

    AST_AN_ABILITY: assert property (
        rd_p1_status |=> mgmt_rdata[`PMSA_BIT_AN_ABILITY] == $past(p1_an_ability))
        else $error("autoneg ability bit wrong");

    AST_LINK: assert property (
        rd_p1_status |=> mgmt_rdata[`PMSA_BIT_LINK] == $past(p1_link_up)
                         && mgmt_hit)
        else $error("link bit wrong");

    AST_ZERO_BITS: assert property (
        (rd_p1_status || rd_p2_status) |=> (mgmt_rdata[10:6] == 5'h00)
                                           && (mgmt_rdata[1:0] == 2'h0))
        else $error("reserved status bits not zero");

    AST_ID_UPPER: assert property (
        served && !mgmt_write && (mgmt_reg_addr == `PMSA_REG_ID_UPPER)
        |=> mgmt_rdata == ID_UPPER)
        else $error("upper identifier wrong");

    AST_ID_LOWER: assert property (
        served && !mgmt_write && (mgmt_reg_addr == `PMSA_REG_ID_LOWER)
        |=> mgmt_rdata == ID_LOWER)
        else $error("lower identifier wrong");

    AST_ADV_WRITE: assert property (
        adv_write && port_sel[0] |=> p1_adv_bits == {$past(mgmt_wdata[10]),
                                                    $past(mgmt_wdata[8:5])})
        else $error("advertisement write not stored");

    AST_ADV_ALIAS: assert property (
        ctl_wr_en && ctl_wr_port2 && !(adv_write && port_sel[1])
        ##1 (mgmt_req && !mgmt_write && port_sel[1]
             && (mgmt_reg_addr == `PMSA_REG_ADVERT))
        |=> mgmt_rdata[8:5] == $past(ctl_wr_bits[3:0], 2)
            && mgmt_rdata[10] == $past(ctl_wr_bits[4], 2)
            && mgmt_rdata[4:0] == `PMSA_SELECTOR)
        else $error("alias write not visible through advertisement");

    AST_PARTNER: assert property (
        rd_p1_partner |=> mgmt_rdata[10] == $past(p1_partner_bits[4])
                          && mgmt_rdata[8:5] == $past(p1_partner_bits[3:0])
                          && mgmt_rdata[4:0] == 5'h00)
        else $error("partner ability wrong");

    AST_NO_ANSWER: assert property (
        mgmt_req && !center_mode && (mgmt_phy_addr != `PMSA_PHYAD_PORT1)
        && (mgmt_phy_addr != `PMSA_PHYAD_PORT2)
        |=> mgmt_ack && !mgmt_hit && (mgmt_rdata == `PMSA_IDLE_WORD))
        else $error("answer at foreign phy address");

    AST_CENTER_ONLY: assert property (
        mgmt_req && center_mode && !center_addr_valid |=> !mgmt_hit)
        else $error("answer before address programmed");

    AST_RO_WRITE: assert property (
        mgmt_req && mgmt_write && (mgmt_reg_addr != `PMSA_REG_ADVERT) && !ctl_wr_en
        |=> $stable(p1_adv_bits) && $stable(p2_adv_bits))
        else $error("read-only write changed storage");

endmodule : pmsa_top
`default_nettype wire

// >>> pmsa_station.sv
// management station model that issues accesses to the phy status bank
`timescale 1ns/1ps
`default_nettype none
module pmsa_station (
    // clock
    input  wire logic                 clk,
    // management request side
    output var logic                  mgmt_req,
    output var logic                  mgmt_write,
    output var pmsa_pkg::pmsa_addr_type mgmt_phy_addr,
    output var pmsa_pkg::pmsa_addr_type mgmt_reg_addr,
    output var pmsa_pkg::pmsa_word_type mgmt_wdata
);
    import pmsa_pkg::*;

    initial begin
        mgmt_req = 1'b0;
        mgmt_write = 1'b0;
        mgmt_phy_addr = 5'h00;
        mgmt_reg_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end

    // one access per high cycle; the bank takes it at the next edge
    task send(input logic w, input pmsa_addr_type phy, input pmsa_addr_type rg,
              input pmsa_word_type wd);
        @(posedge clk);
        mgmt_req <= 1'b1;
        mgmt_write <= w;
        mgmt_phy_addr <= phy;
        mgmt_reg_addr <= rg;
        mgmt_wdata <= wd;
    endtask : send

    // released lines flip so stale values never look valid
    task idle;
        @(posedge clk);
        mgmt_req <= 1'b0;
        mgmt_write <= ~mgmt_write;
        mgmt_phy_addr <= ~mgmt_phy_addr;
        mgmt_reg_addr <= ~mgmt_reg_addr;
        mgmt_wdata <= ~mgmt_wdata;
    endtask : idle
endmodule : pmsa_station
`default_nettype wire

// >>> phy_mii_status_ability_regs_test.sv
// self-checking bench of the phy status, identifier and ability bank
`timescale 1ns/1ps
`default_nettype none
module phy_mii_status_ability_regs_test;
    import pmsa_pkg::*;
    localparam logic [15:0] ID_U = 16'h6B21; // arbitrary
    localparam logic [15:0] ID_L = 16'h49D3; // arbitrary
    logic clk, rst_b, mgmt_req, mgmt_write, mgmt_ack, mgmt_hit;
    pmsa_addr_type mgmt_phy_addr, mgmt_reg_addr, center_phy_addr, m_ca;
    pmsa_word_type mgmt_wdata, mgmt_rdata;
    logic center_mode, center_addr_valid, ctl_wr_en, ctl_wr_port2, m_cm, m_cv;
    logic p1_link_up, p1_an_done, p1_an_ability, p1_far_end_fault;
    logic p2_link_up, p2_an_done, p2_an_ability, m_fault, req_d;
    pmsa_ability_type ctl_wr_bits, p1_partner_bits, p2_partner_bits, p1_adv_bits, p2_adv_bits;
    pmsa_ability_type m_pb [2];
    pmsa_ability_type m_adv [2];
    logic [1:0] m_link, m_an, m_ab;
    logic [16:0] exp_q [$];
    logic [16:0] e;
    logic [31:0] rng, w;
    int fail_count, n_compared, cycles;

    pmsa_station u_pmsa_station (.clk(clk), .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
        .mgmt_phy_addr(mgmt_phy_addr), .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata));
    pmsa_top #(.ID_UPPER(ID_U), .ID_LOWER(ID_L)) u_pmsa_top (.clk(clk), .rst_b(rst_b),
        .mgmt_req(mgmt_req), .mgmt_write(mgmt_write), .mgmt_phy_addr(mgmt_phy_addr),
        .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
        .mgmt_hit(mgmt_hit), .mgmt_rdata(mgmt_rdata), .center_mode(center_mode),
        .center_addr_valid(center_addr_valid), .center_phy_addr(center_phy_addr),
        .ctl_wr_en(ctl_wr_en), .ctl_wr_port2(ctl_wr_port2), .ctl_wr_bits(ctl_wr_bits),
        .p1_link_up(p1_link_up), .p1_an_done(p1_an_done), .p1_an_ability(p1_an_ability),
        .p1_far_end_fault(p1_far_end_fault), .p1_partner_bits(p1_partner_bits),
        .p2_link_up(p2_link_up), .p2_an_done(p2_an_done), .p2_an_ability(p2_an_ability),
        .p2_partner_bits(p2_partner_bits), .p1_adv_bits(p1_adv_bits), .p2_adv_bits(p2_adv_bits));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs;
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // expected {hit, rdata}; a served write to register 4 also updates the advertisement model
    function automatic logic [16:0] expect_of(logic wr, pmsa_addr_type phy, pmsa_addr_type rg,
                                              pmsa_word_type wd);
        int p;
        pmsa_word_type d;
        p = (phy == 5'h01) ? 0 : (phy == 5'h02) ? 1 : -1;
        if (m_cm) p = (m_cv && phy == m_ca) ? 0 : -1;
        if (p < 0 || rg == 5'h00 || rg > 5'h05) return {1'b0, 16'hFFFF};
        if (wr) begin
            if (rg == 5'h04) m_adv[p] = {wd[10], wd[8:5]};
            return {1'b1, 16'hFFFF};
        end
        case (rg)
            5'h01: d = {5'h0F, 5'h00, m_an[p], m_fault & (p == 0), m_ab[p], m_link[p], 2'b00};
            5'h02: d = ID_U;
            5'h03: d = ID_L;
            5'h04: d = {5'h00, m_adv[p][4], 1'b0, m_adv[p][3:0], 5'h01};
            default: d = {5'h00, m_pb[p][4], 1'b0, m_pb[p][3:0], 5'h00};
        endcase
        return {1'b1, d};
    endfunction : expect_of

    task acc(input logic wr, input pmsa_addr_type phy, input pmsa_addr_type rg,
             input pmsa_word_type wd);
        exp_q.push_back(expect_of(wr, phy, rg, wd));
        u_pmsa_station.send(wr, phy, rg, wd);
    endtask : acc

    task new_state;
        w = xs();
        u_pmsa_station.idle();
        {m_link, m_an, m_ab, m_fault} = w[6:0];
        m_pb[0] = w[11:7];
        m_pb[1] = w[16:12];
        {p2_link_up, p1_link_up} <= w[6:5];
        {p2_an_done, p1_an_done} <= w[4:3];
        {p2_an_ability, p1_an_ability} <= w[2:1];
        p1_far_end_fault <= w[0];
        p1_partner_bits <= w[11:7];
        p2_partner_bits <= w[16:12];
    endtask : new_state

    task chk_adv;
        u_pmsa_station.idle();
        #1;
        chk("p1_adv_bits", {11'h000, p1_adv_bits}, {11'h000, m_adv[0]});
        chk("p2_adv_bits", {11'h000, p2_adv_bits}, {11'h000, m_adv[1]});
    endtask : chk_adv

    // results pair with the oldest note; ack must follow a request by one cycle
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("wrong value cycles expected below 20000 seen 20000");
            finish_test();
        end
        if (rst_b === 1'b1) begin
            chk("mgmt_ack", {15'h0000, mgmt_ack}, {15'h0000, req_d});
            if (mgmt_ack === 1'b1 && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk("mgmt_hit", {15'h0000, mgmt_hit}, {15'h0000, e[16]});
                chk("mgmt_rdata", mgmt_rdata, e[15:0]);
            end
        end
        req_d = mgmt_req & rst_b;
    end

    initial begin
        rng = 32'hFC388494;
        rst_b = 1'b0;
        {center_mode, center_addr_valid, ctl_wr_en, ctl_wr_port2, m_cm, m_cv} = 6'h00;
        {center_phy_addr, m_ca, ctl_wr_bits} = 15'h0000;
        {p1_link_up, p1_an_done, p1_an_ability, p1_far_end_fault} = 4'h0;
        {p2_link_up, p2_an_done, p2_an_ability, p1_partner_bits, p2_partner_bits} = 13'h0000;
        m_adv[0] = 5'h1F;
        m_adv[1] = 5'h1F;
        repeat (3) @(posedge clk);
        chk("mgmt_rdata", mgmt_rdata, 16'hFFFF);
        chk_adv();
        rst_b <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            new_state();
            for (int a = 0; a < 4; a++) for (int r = 0; r < 7; r++) acc(1'b0, a[4:0], r[4:0], 16'h0000);
        end
        for (int i = 0; i < 40; i++) begin
            w = xs();
            acc(1'b1, {4'h0, w[16]} + 5'h01, w[18] ? 5'h04 : {2'b00, w[21:19]}, w[15:0]);
            for (int r = 1; r < 6; r++) acc(1'b0, {4'h0, w[16]} + 5'h01, r[4:0], 16'h0000);
            chk_adv();
        end
        // alias writes, some colliding with a management write to the same port
        for (int i = 0; i < 30; i++) begin
            w = xs();
            m_adv[w[5]] = w[4:0];
            if (w[6]) acc(1'b1, {4'h0, w[5]} + 5'h01, 5'h04, w[31:16]);
            else u_pmsa_station.idle();
            ctl_wr_en <= 1'b1;
            ctl_wr_port2 <= w[5];
            ctl_wr_bits <= w[4:0];
            // read back in the very next cycle: the alias shows one edge after it lands
            acc(1'b0, {4'h0, w[5]} + 5'h01, 5'h04, 16'h0000);
            ctl_wr_en <= 1'b0;
            chk_adv();
        end
        for (int v = 0; v < 2; v++) begin
            u_pmsa_station.idle();
            {center_mode, center_addr_valid, center_phy_addr} <= {1'b1, v[0], 5'h07};
            {m_cm, m_cv, m_ca} = {1'b1, v[0], 5'h07};
            for (int a = 0; a < 8; a++) acc(1'b0, a[4:0], 5'h01, 16'h0000);
            for (int a = 0; a < 8; a++) begin
                w = xs();
                acc(1'b1, a[4:0], 5'h04, w[15:0]);
            end
            acc(1'b0, 5'h07, 5'h04, 16'h0000);
            chk_adv();
        end
        center_mode <= 1'b0;
        m_cm = 1'b0;
        repeat (2) u_pmsa_station.idle();
        rst_b <= 1'b0;
        m_adv[0] = 5'h1F;
        m_adv[1] = 5'h1F;
        chk_adv();
        rst_b <= 1'b1;
        acc(1'b0, 5'h01, 5'h04, 16'h0000);
        acc(1'b0, 5'h02, 5'h04, 16'h0000);
        repeat (3) u_pmsa_station.idle();
        chk("pending", 16'(exp_q.size()), 16'h0000);
        finish_test();
    end
endmodule : phy_mii_status_ability_regs_test
`default_nettype wire
